// *** nsr_params.svh ***
// Register offsets, widths, reset values and decode codes of the status and driver register bank
`ifndef NSR_PARAMS_SVH
`define NSR_PARAMS_SVH

`define NSR_ADDR_W          8
`define NSR_DATA_W          8
`define NSR_OFS_DISPLAY     8'h24
`define NSR_OFS_CONV        8'h25
`define NSR_OFS_TUNE_A      8'h26
`define NSR_OFS_TUNE_B      8'h27
`define NSR_OFS_TXDRV       8'h28
`define NSR_RST_TUNE        8'h80
`define NSR_RST_TXDRV       8'h70
`define NSR_RST_MOD_IDX     4'h7
`define NSR_RST_DRES        4'h0
`define NSR_RST_ZERO        8'h00
`define NSR_HIGHZ_CODE      4'hF
`define NSR_NO_MOD_CODE     4'h0

`endif

// *** nsr_pkg.sv ***
// Types shared by the status and transmit driver register bank
`default_nettype none
package nsr_pkg;
    typedef struct packed {
        logic       guard_two_run;
        logic       general_run;
        logic       no_response_run;
        logic       mask_receive_run;
    } nsr_timers_s;

    typedef struct packed {
        logic [3:0] modulation_depth_index;
        logic [3:0] drive_res_code;
    } nsr_txdrv_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nsr_bus_s;
endpackage
`default_nettype wire

// *** nsr_regs.sv ***
// Status display and transmit driver register bank of the reader front end
//
// Summary of operation
// - Bits 5:4 show detected target bit rate.
// - Bit 2 high while general timer counts.
// - Bit 1 high while no-response timer runs.
// - Bit 0 high while mask-receive timer runs.
// - Bit 3 shows second guard timer running.
// - Conversion result updates only on completion.
// - First tuning register, resets to 80h.
// - Second tuning register, resets to 80h.
// - Bits 7:4 set modulation depth index.
// - Bits 3:0 set driver resistance, 15 off.
`include "nsr_params.svh"
`default_nettype none
module nsr_regs
    import nsr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Status from the surrounding front end
    input  wire logic [1:0]  detected_rate,
    input  wire nsr_timers_s timers_async,
    input  wire logic        conv_done,
    input  wire logic [7:0]  conv_value,
    // Settings to the analog side
    output logic      [7:0]  tune_first,
    output logic      [7:0]  tune_second,
    output logic      [3:0]  modulation_depth_index,
    output logic      [3:0]  drive_res_code,
    output logic             driver_high_z,
    output logic             modulation_off
);
    // ------------------------------------------------------------
    // Status capture
    // ------------------------------------------------------------
    // Timer flags and rate come from other logic that may run on its own
    // clock, so all six bits pass two flops before display.
    logic [5:0]  status_sync;
    nsr_timers_s timers_sync;
    logic [1:0]  rate_sync;

    nsr_sync #(
        .W(6)
    ) u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in ({detected_rate, timers_async}),
        .sync_out (status_sync)
    );

    assign rate_sync   = status_sync[5:4];
    assign timers_sync = status_sync[3:0];

    logic [7:0] display_reg;
    logic [7:0] display_next;

    always_comb begin
        display_next      = `NSR_RST_ZERO;
        display_next[5:4] = rate_sync;
        display_next[3]   = timers_sync.guard_two_run;
        display_next[2]   = timers_sync.general_run;
        display_next[1]   = timers_sync.no_response_run;
        display_next[0]   = timers_sync.mask_receive_run;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            display_reg <= `NSR_RST_ZERO;
        end else begin
            display_reg <= display_next;
        end
    end

    // ------------------------------------------------------------
    // Conversion result
    // ------------------------------------------------------------
    // The converter strobe is assumed to be on this clock, with the value
    // stable beside it; the result is held between conversions.
    logic [7:0] conv_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conv_reg <= `NSR_RST_ZERO;
        end else if (conv_done) begin
            conv_reg <= conv_value;
        end
    end

    // ------------------------------------------------------------
    // Writable settings
    // ------------------------------------------------------------
    logic       wr_tune_a;
    logic       wr_tune_b;
    logic       wr_txdrv;
    nsr_txdrv_s txdrv_reg;

    assign wr_tune_a = reg_wr && (reg_addr == `NSR_OFS_TUNE_A);
    assign wr_tune_b = reg_wr && (reg_addr == `NSR_OFS_TUNE_B);
    assign wr_txdrv  = reg_wr && (reg_addr == `NSR_OFS_TXDRV);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tune_first <= `NSR_RST_TUNE;
        end else if (wr_tune_a) begin
            tune_first <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tune_second <= `NSR_RST_TUNE;
        end else if (wr_tune_b) begin
            tune_second <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txdrv_reg <= nsr_txdrv_s'(`NSR_RST_TXDRV);
        end else if (wr_txdrv) begin
            txdrv_reg <= nsr_txdrv_s'(reg_wdata);
        end
    end

    // ------------------------------------------------------------
    // Driver controls
    // ------------------------------------------------------------
    // Decoded flags are registered from the next value so they change in
    // the same cycle as the fields, keeping every output a flop.
    nsr_txdrv_s txdrv_next;

    always_comb begin
        txdrv_next = txdrv_reg;
        if (wr_txdrv) begin
            txdrv_next = nsr_txdrv_s'(reg_wdata);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            modulation_depth_index <= `NSR_RST_MOD_IDX;
            drive_res_code         <= `NSR_RST_DRES;
            driver_high_z          <= 1'b0;
            modulation_off         <= 1'b0;
        end else begin
            modulation_depth_index <= txdrv_next.modulation_depth_index;
            modulation_off <= (txdrv_next.modulation_depth_index == `NSR_NO_MOD_CODE);
            drive_res_code <= txdrv_next.drive_res_code;
            driver_high_z  <= (txdrv_next.drive_res_code == `NSR_HIGHZ_CODE);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Writes to the two display registers fall through the decode and
    // change nothing; unmapped reads return zero.
    logic [7:0] rdata_next;

    always_comb begin
        rdata_next = `NSR_RST_ZERO;
        unique case (reg_addr)
            `NSR_OFS_DISPLAY: begin
                rdata_next = display_reg;
            end
            `NSR_OFS_CONV: begin
                // A read in the completing cycle already sees the new result
                if (conv_done) begin
                    rdata_next = conv_value;
                end else begin
                    rdata_next = conv_reg;
                end
            end
            `NSR_OFS_TUNE_A: begin
                rdata_next = tune_first;
            end
            `NSR_OFS_TUNE_B: begin
                rdata_next = tune_second;
            end
            `NSR_OFS_TXDRV: begin
                rdata_next = txdrv_reg;
            end
            default: begin
                rdata_next = `NSR_RST_ZERO;
            end
        endcase
    end

    // Data stands only in the cycle after the read strobe, zero otherwise.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= `NSR_RST_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= `NSR_RST_ZERO;
        end
    end
endmodule
`default_nettype wire

// *** nsr_regs_monitor.sv ***
// Port assertions for the status and driver register bank
`default_nettype none
module nsr_regs_monitor
    import nsr_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [1:0]  detected_rate,
    input wire nsr_timers_s timers_async,
    input wire logic        conv_done,
    input wire logic [7:0]  conv_value,
    input wire logic [7:0]  tune_first,
    input wire logic [7:0]  tune_second,
    input wire logic [3:0]  modulation_depth_index,
    input wire logic [3:0]  drive_res_code,
    input wire logic        driver_high_z,
    input wire logic        modulation_off
);
    // ----------------------------------------
    // Register port relations
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_tune_a_rd: assert property (reg_rd && reg_addr == 8'h26 |=> reg_rdata == tune_first)
        else $error("first tuning readback differs");
    chk_tune_b_rd: assert property (reg_rd && reg_addr == 8'h27 |=> reg_rdata == tune_second)
        else $error("second tuning readback differs");
    chk_tune_a_wr: assert property (reg_wr && reg_addr == 8'h26 |=> tune_first == $past(reg_wdata))
        else $error("first tuning write lost");
    chk_txdrv_rd: assert property (reg_rd && reg_addr == 8'h28 |=>
        reg_rdata == {modulation_depth_index, drive_res_code})
        else $error("driver readback differs");
    chk_txdrv_wr: assert property (reg_wr && reg_addr == 8'h28 |=>
        {modulation_depth_index, drive_res_code} == $past(reg_wdata))
        else $error("driver write lost");
    chk_high_z: assert property (driver_high_z == (drive_res_code == 4'hF))
        else $error("high impedance decode wrong");
    chk_mod_off: assert property (modulation_off == (modulation_depth_index == 4'h0))
        else $error("no modulation decode wrong");
    chk_rsv_zero: assert property (reg_rd && reg_addr == 8'h24 |=> reg_rdata[7:6] == 2'h0)
        else $error("reserved display bits set");
    chk_conv_rd: assert property (reg_rd && reg_addr == 8'h25 && conv_done |=>
        reg_rdata == $past(conv_value))
        else $error("new conversion result not read");
endmodule
bind nsr_regs nsr_regs_monitor u_mon (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .detected_rate(detected_rate), .timers_async(timers_async), .conv_done(conv_done),
    .conv_value(conv_value), .tune_first(tune_first), .tune_second(tune_second),
    .modulation_depth_index(modulation_depth_index), .drive_res_code(drive_res_code),
    .driver_high_z(driver_high_z), .modulation_off(modulation_off));
`default_nettype wire

// *** nsr_sync.sv ***
// Two-flop synchroniser, one per bit, for inputs from outside the clock domain
`default_nettype none
module nsr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_reg[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// *** tb_nsr_regs.sv ***
// Self-checking bench for the status and driver register bank
`default_nettype none
module tb_nsr_regs
    import nsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} nsr_row_s;
    logic        clk, arst_n, reg_wr, reg_rd, conv_done, driver_high_z, modulation_off;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, conv_value, tune_first, tune_second, v;
    logic [3:0]  modulation_depth_index, drive_res_code;
    logic [1:0]  detected_rate;
    nsr_timers_s timers_async;
    int          errors, tests_run;
    // Read-only and unmapped rows expect the display, the captured result and zero
    nsr_row_s rows [7] = '{'{8'h26, 8'h55, 8'h55}, '{8'h27, 8'hAA, 8'hAA},
        '{8'h28, 8'hF3, 8'hF3}, '{8'h24, 8'hFF, 8'h2A}, '{8'h25, 8'h00, 8'h3C},
        '{8'h30, 8'h77, 8'h00}, '{8'h28, 8'h0F, 8'h0F}};

    nsr_regs DUT (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .detected_rate(detected_rate),
        .timers_async(timers_async), .conv_done(conv_done), .conv_value(conv_value),
        .tune_first(tune_first), .tune_second(tune_second),
        .modulation_depth_index(modulation_depth_index), .drive_res_code(drive_res_code),
        .driver_high_z(driver_high_z), .modulation_off(modulation_off));

    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic finish_test();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        finish_test();
    end
    initial begin
        arst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
        detected_rate = 0; timers_async = 0; conv_done = 0; conv_value = 0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h26, v); chk(v, 8'h80);
        rd(8'h27, v); chk(v, 8'h80);
        rd(8'h28, v); chk(v, 8'h70);
        rd(8'h24, v); chk(v, 8'h00);
        // Read in the very cycle the conversion completes
        @(posedge clk);
        detected_rate <= 2'h2; timers_async <= 4'hA; conv_value <= 8'h3C; conv_done <= 1;
        reg_rd <= 1; reg_addr <= 8'h25;
        @(posedge clk);
        conv_done <= 0; reg_rd <= 0; conv_value <= 8'hC3;
        @(negedge clk);
        chk(reg_rdata, 8'h3C);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk(v, rows[i].e);
        end
        chk(driver_high_z, 1'b1);
        chk(modulation_off, 1'b1);
        chk(tune_second, 8'hAA);
        // Every timer bit flips, then settles through the synchroniser
        timers_async <= 4'h5; detected_rate <= 2'h1;
        repeat (3) @(posedge clk);
        rd(8'h24, v); chk(v, 8'h15);
        arst_n <= 1'b0;
        @(negedge clk);
        chk(tune_first, 8'h80);
        chk({modulation_depth_index, drive_res_code}, 8'h70);
        @(posedge clk);
        arst_n <= 1'b1;
        finish_test();
    end
endmodule
`default_nettype wire
